// ==== core/std_timer_regs.vh ====
// Purpose: register offsets, field positions and reset values of the 16-bit timer
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: narrow registers sit in the low bits, upper bits read as zero
`ifndef STD_TIMER_REGS_VH
`define STD_TIMER_REGS_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADDR_CTRL0 12'h000
`define ADDR_CTRL1 12'h004
`define ADDR_CNT_LO 12'h008
`define ADDR_CNT_HI 12'h00C
`define ADDR_CMPA_LO 12'h010
`define ADDR_CMPA_HI 12'h014
`define ADDR_CMPP 12'h018
`define ADDR_FLAGS 12'h01C

// ----------------------------------------------------------------
// control 0 fields
// ----------------------------------------------------------------
`define C0_PAUSE 7
`define C0_CKSEL_HI 6
`define C0_CKSEL_LO 4
`define C0_ENABLE 3

// ----------------------------------------------------------------
// control 1 fields
// ----------------------------------------------------------------
`define C1_MODE_HI 7
`define C1_MODE_LO 6
`define C1_PINF_HI 5
`define C1_PINF_LO 4
`define C1_OCTL 3
`define C1_POL 2
`define C1_DPX 1
`define C1_CCLR 0

// ----------------------------------------------------------------
// flag register fields (write one to clear)
// ----------------------------------------------------------------
`define FL_MATCH_A 0
`define FL_MATCH_P 1

// ----------------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------------
`define MODE_CMP 2'h0
`define MODE_PWM 2'h2
`define MODE_TMR 2'h3
`define PINF_NONE 2'h0
`define PINF_LOW 2'h1
`define PINF_HIGH 2'h2
`define PINF_TOGGLE 2'h3
`define CK_DIV4 3'h0
`define CK_SYS 3'h1
`define CK_DIV16 3'h2
`define CK_DIV64 3'h3
`define CK_EXT_RISE 3'h6
`define CK_EXT_FALL 3'h7
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define CNT_MAX 16'hFFFF
`define CNT_ONE 16'h0001
`define PRE_ONE 6'h01
`define PRE_DIV4 6'h03
`define PRE_DIV16 6'h0F
`define PRE_DIV64 6'h3F

`endif

// ==== core/std_timer.v ====
// Purpose: 16-bit count-up timer with two comparators, APB slave
// Assumes: all inputs synchronous to pclk
// Notes: slow internal clocks fsub and fh are taken as pclk prescaled
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "std_timer_regs.vh"

module std_timer
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ext_clock_pin,
  output reg timer_output_pin,
  output reg timer_output_oe,
  output reg match_a_flag,
  output reg match_p_flag
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [7:0] ctrl0_q;
  reg [7:0] ctrl1_q;
  reg [15:0] count_q;
  reg [15:0] compare_a_value;
  reg [7:0] compare_p_value;
  reg [5:0] pre_q;
  reg ext_q;
  reg en_prev_q;
  reg pin_q;
  reg full_q;

  wire counter_pause = ctrl0_q[`C0_PAUSE];
  wire [2:0] clk_sel = ctrl0_q[`C0_CKSEL_HI:`C0_CKSEL_LO];
  wire timer_enable = ctrl0_q[`C0_ENABLE];
  wire [1:0] mode_sel = ctrl1_q[`C1_MODE_HI:`C1_MODE_LO];
  wire [1:0] pin_func = ctrl1_q[`C1_PINF_HI:`C1_PINF_LO];
  wire output_control = ctrl1_q[`C1_OCTL];
  wire output_polarity = ctrl1_q[`C1_POL];
  wire duty_period_swap = ctrl1_q[`C1_DPX];
  wire clear_select = ctrl1_q[`C1_CCLR];

  wire is_pwm = (mode_sel == `MODE_PWM);
  wire is_pulse = is_pwm && (pin_func == `PINF_TOGGLE);
  wire cmp_like = (mode_sel == `MODE_CMP) || (mode_sel == `MODE_TMR);

  // apb phases
  wire wr_acc = psel && penable && pwrite && pready;
  wire rd_setup = psel && !penable && !pwrite;

  // ----------------------------------------------------------------
  // clock tick selection
  // ----------------------------------------------------------------
  wire ext_rise = ext_clock_pin && !ext_q;
  wire ext_fall = !ext_clock_pin && ext_q;
  wire ext_edge = (clk_sel == `CK_EXT_FALL) ? ext_fall : ext_rise;
  reg tick;

  // prescaler taps give the internal rates
  always @*
  begin
    case (clk_sel)
      `CK_DIV4: tick = (pre_q[1:0] == `PRE_DIV4);
      `CK_SYS: tick = 1'b1;
      `CK_DIV16: tick = (pre_q[3:0] == `PRE_DIV16);
      `CK_DIV64: tick = (pre_q == `PRE_DIV64);
      `CK_EXT_RISE: tick = ext_rise;
      `CK_EXT_FALL: tick = ext_fall;
      default: tick = (pre_q == `PRE_DIV64);
    endcase
  end

  // ----------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------
  wire run = timer_enable && !counter_pause && tick;
  wire [15:0] cnt_inc = count_q + `CNT_ONE;
  wire a_hit = run && (compare_a_value != `RST_WORD) && (cnt_inc == compare_a_value);
  wire p_zero = (compare_p_value == `RST_BYTE);
  wire p_hit = run && (p_zero ? (count_q == `CNT_MAX)
    : ((cnt_inc[15:8] == compare_p_value) && (cnt_inc[7:0] == `RST_BYTE)));
  wire ovf = run && (count_q == `CNT_MAX);

  reg clear_now;
  reg set_a;
  reg set_p;

  // clear source and flags per mode
  always @*
  begin
    clear_now = 1'b0;
    set_a = 1'b0;
    set_p = 1'b0;
    if (cmp_like)
    begin
      if (clear_select)
      begin
        clear_now = a_hit || ovf;
        set_a = a_hit;
      end
      else
      begin
        clear_now = p_hit;
        set_a = a_hit;
        set_p = p_hit;
      end
    end
    else if (is_pulse)
    begin
      set_a = a_hit;
    end
    else if (is_pwm)
    begin
      clear_now = duty_period_swap ? (a_hit || ovf) : p_hit;
      set_a = a_hit;
      set_p = p_hit;
    end
  end

  // pwm period restart, duty reached
  wire pwm_wrap = is_pwm && !is_pulse && clear_now;
  wire duty_hit = duty_period_swap ? p_hit : a_hit;

  // software enable write and hardware triggers
  wire sw_en_wr = wr_acc && (paddr == `ADDR_CTRL0);
  wire en_next = sw_en_wr ? pwdata[`C0_ENABLE] : timer_enable;
  wire en_rise = timer_enable && !en_prev_q;

  // ----------------------------------------------------------------
  // registers and counter
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl0_q <= `RST_BYTE;
      ctrl1_q <= `RST_BYTE;
      count_q <= `RST_WORD;
      compare_a_value <= `RST_WORD;
      compare_p_value <= `RST_BYTE;
      pre_q <= 6'h00;
      ext_q <= 1'b0;
      en_prev_q <= 1'b0;
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
    end
    else
    begin
      pre_q <= pre_q + `PRE_ONE;
      ext_q <= ext_clock_pin;
      en_prev_q <= timer_enable;
      // register writes
      if (wr_acc)
      begin
        case (paddr)
          `ADDR_CTRL1: ctrl1_q <= pwdata[7:0];
          `ADDR_CMPA_LO: compare_a_value[7:0] <= pwdata[7:0];
          `ADDR_CMPA_HI: compare_a_value[15:8] <= pwdata[7:0];
          `ADDR_CMPP: compare_p_value <= pwdata[7:0];
          default: ;
        endcase
      end
      // control 0, with hardware set and clear of enable
      ctrl0_q[7:4] <= sw_en_wr ? pwdata[7:4] : ctrl0_q[7:4];
      ctrl0_q[2:0] <= 3'h0;
      if (is_pulse && en_next && a_hit)
        ctrl0_q[`C0_ENABLE] <= 1'b0;
      else if (is_pulse && (clk_sel[2:1] == 2'h3) && ext_edge)
        ctrl0_q[`C0_ENABLE] <= 1'b1;
      else
        ctrl0_q[`C0_ENABLE] <= en_next;
      // counter
      if (en_rise)
        count_q <= `RST_WORD;
      else if (run)
        count_q <= clear_now ? `RST_WORD : cnt_inc;
      // flags: set wins over write-one-clear
      if (set_a)
        match_a_flag <= 1'b1;
      else if (wr_acc && (paddr == `ADDR_FLAGS) && pwdata[`FL_MATCH_A])
        match_a_flag <= 1'b0;
      if (set_p)
        match_p_flag <= 1'b1;
      else if (wr_acc && (paddr == `ADDR_FLAGS) && pwdata[`FL_MATCH_P])
        match_p_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // output pin
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_q <= 1'b0;
      full_q <= 1'b0;
      timer_output_pin <= 1'b0;
      timer_output_oe <= 1'b0;
    end
    else
    begin
      // raw level before polarity
      if (en_rise)
      begin
        pin_q <= is_pwm && !is_pulse ? 1'b1 : output_control;
        full_q <= 1'b0;
      end
      else if (mode_sel == `MODE_CMP && set_a)
      begin
        case (pin_func)
          `PINF_LOW: pin_q <= 1'b0;
          `PINF_HIGH: pin_q <= 1'b1;
          `PINF_TOGGLE: pin_q <= !pin_q;
          default: pin_q <= pin_q;
        endcase
      end
      // trailing edge lands on the match edge itself, not one tick later
      else if (is_pulse && (!en_next || set_a))
        pin_q <= !output_control;
      else if (pwm_wrap)
        pin_q <= 1'b1; // period start: active
      else if (is_pwm && !is_pulse && duty_hit && !full_q)
        pin_q <= 1'b0; // duty ends unless already wrapped
      if (pwm_wrap && duty_hit)
        full_q <= 1'b1;
      // drive pin
      timer_output_oe <= (mode_sel != `MODE_TMR) && (mode_sel != 2'h1);
      if (is_pwm && !is_pulse)
      begin
        case (pin_func)
          `PINF_NONE: timer_output_pin <= !output_control ^ output_polarity;
          `PINF_LOW: timer_output_pin <= output_control ^ output_polarity;
          default: timer_output_pin <= (pin_q ? output_control : !output_control)
            ^ output_polarity;
        endcase
      end
      else
        timer_output_pin <= pin_q ^ output_polarity;
    end
  end

  // ----------------------------------------------------------------
  // apb read and handshake
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr > `ADDR_FLAGS);
      if (rd_setup)
      begin
        case (paddr)
          `ADDR_CTRL0: prdata <= {24'h000000, ctrl0_q};
          `ADDR_CTRL1: prdata <= {24'h000000, ctrl1_q};
          `ADDR_CNT_LO: prdata <= {24'h000000, count_q[7:0]};
          `ADDR_CNT_HI: prdata <= {24'h000000, count_q[15:8]};
          `ADDR_CMPA_LO: prdata <= {24'h000000, compare_a_value[7:0]};
          `ADDR_CMPA_HI: prdata <= {24'h000000, compare_a_value[15:8]};
          `ADDR_CMPP: prdata <= {24'h000000, compare_p_value};
          `ADDR_FLAGS: prdata <= {30'h00000000, match_p_flag, match_a_flag};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // std_timer
`default_nettype wire

// ==== verification/std_timer_asserts.sv ====
// Purpose: port-level checks of the timer bus answer and sticky flags
// Assumes: single pclk domain, presetn asynchronous active low
// Notes: bound to every std_timer instance
`timescale 1ns/1ps
`default_nettype none
`include "std_timer_regs.vh"
module std_timer_asserts
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ext_clock_pin,
  input wire logic timer_output_pin,
  input wire logic timer_output_oe,
  input wire logic match_a_flag,
  input wire logic match_p_flag
);
  // ----------
  // bus and flag properties
  // ----------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // setup phase and flag clear decode
  wire setup_w = psel && !penable;
  wire fl_wr_w = pready && pwrite && paddr == `ADDR_FLAGS;
  property p_rdy; setup_w |=> pready; endproperty
  property p_rdy_only; pready |-> psel && penable && $past(setup_w); endproperty
  property p_err; setup_w && paddr > `ADDR_FLAGS |=> pslverr; endproperty
  property p_no_err; setup_w && paddr <= `ADDR_FLAGS |=> !pslverr; endproperty
  property p_err_pair; pslverr |-> pready; endproperty
  property p_err_rd; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  property p_byte; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  property p_a_clr; $fell(match_a_flag) |-> $past(fl_wr_w && pwdata[`FL_MATCH_A]); endproperty
  property p_p_clr; $fell(match_p_flag) |-> $past(fl_wr_w && pwdata[`FL_MATCH_P]); endproperty
  a_rdy: assert property (p_rdy) else $error("no pready after setup");
  a_rdy_only: assert property (p_rdy_only) else $error("pready outside access");
  a_err: assert property (p_err) else $error("no pslverr on unmapped address");
  a_no_err: assert property (p_no_err) else $error("pslverr on mapped address");
  a_err_pair: assert property (p_err_pair) else $error("pslverr without pready");
  a_err_rd: assert property (p_err_rd) else $error("unmapped read not zero");
  a_byte: assert property (p_byte) else $error("upper read bits set");
  a_a_clr: assert property (p_a_clr) else $error("flag a fell untold");
  a_p_clr: assert property (p_p_clr) else $error("flag p fell untold");
  // main scenarios reached
  c_err: cover property (pslverr);
  c_pf: cover property ($rose(match_p_flag));
  c_pin: cover property ($rose(timer_output_pin));
endmodule // std_timer_asserts
bind std_timer std_timer_asserts std_timer_asserts_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clock_pin(ext_clock_pin),
  .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe),
  .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));
`default_nettype wire

// ==== verification/std_timer_tb.sv ====
// Purpose: self-checking bench for std_timer over APB
// Assumes: counter clock select 001 (pclk) except the pin trigger test
// Notes: pin timing is measured between pin changes
`timescale 1ns/1ps
`default_nettype none
`include "std_timer_regs.vh"
module std_timer_tb;
  // ----------
  // bench signals and design
  // ----------
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic ext_clock_pin = 1'h0, err, lvl, hl;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rv, r0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, timer_output_pin, timer_output_oe, match_a_flag, match_p_flag;
  int failures = 0, check_count = 0, c, c2;
  logic [7:0] cmv [3] = '{8'h19, 8'h09, 8'h21};
  logic cex [3] = '{1'h0, 1'h1, 1'h1};
  logic [7:0] c1v [4] = '{8'hAA, 8'h88, 8'h98, 8'h9C};
  logic pex [4] = '{1'h1, 1'h0, 1'h1, 1'h0};
  std_timer std_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clock_pin(ext_clock_pin), .timer_output_pin(timer_output_pin),
    .timer_output_oe(timer_output_oe), .match_a_flag(match_a_flag),
    .match_p_flag(match_p_flag));
  // clock of 50 ns period
  initial forever #25 pclk = ~pclk;
  // watchdog against a hung wait
  initial
  begin
    repeat (10000) @(posedge pclk);
    failures++;
    conclude();
  end
  // one apb transfer, held until pready
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rv = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'h1, d);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string n);
    xfer(a, 1'h0, 32'h0);
    chk(n, e, rv);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // cycles until the pin leaves its present level, at most lim
  task automatic meas(input int lim);
    lvl = timer_output_pin;
    c = 0;
    while (timer_output_pin === lvl && c < lim)
    begin
      @(posedge pclk);
      c++;
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------
  // tests
  // ----------
  initial
  begin
    tick(4);
    presetn <= 1'h1;
    for (int i = 2; i < 7; i++) rdc(12'(i * 4), 32'h0, "reset value");
    wr(`ADDR_CNT_LO, 32'hAB);
    rdc(`ADDR_CNT_LO, 32'h0, "counter low");
    wr(`ADDR_CMPA_LO, 32'hFFFFFF12);
    wr(`ADDR_CMPA_HI, 32'h34);
    wr(`ADDR_CMPP, 32'h56);
    rdc(`ADDR_CMPA_LO, 32'h12, "compare a low");
    rdc(`ADDR_CMPA_HI, 32'h34, "compare a high");
    rdc(`ADDR_CMPP, 32'h56, "compare p");
    xfer(12'h020, 1'h0, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    $display("test registers done");
    // compare mode, toggle on A match, A clears
    wr(`ADDR_CMPA_HI, 32'h0);
    wr(`ADDR_CMPA_LO, 32'h10);
    wr(`ADDR_CTRL1, 32'h39);
    wr(`ADDR_CTRL0, 32'h18);
    tick(3);
    chk("initial level", 32'h1, 32'(timer_output_pin));
    meas(100);
    meas(100);
    chk("toggle period", 32'h10, 32'(c));
    chk("flags", 32'h1, 32'({match_p_flag, match_a_flag}));
    chk("pin enable", 32'h1, 32'(timer_output_oe));
    for (int k = 0; k < 3; k++)
    begin
      wr(`ADDR_CTRL0, 32'h0);
      wr(`ADDR_CTRL1, 32'(cmv[k]));
      wr(`ADDR_CTRL0, 32'h18);
      tick(3);
      chk("start level", 32'(cmv[k][3]), 32'(timer_output_pin));
      tick(20);
      chk("match level", 32'(cex[k]), 32'(timer_output_pin));
    end
    wr(`ADDR_CTRL0, 32'h0);
    wr(`ADDR_FLAGS, 32'h3);
    rdc(`ADDR_FLAGS, 32'h0, "flags cleared");
    $display("test compare done");
    // timer mode, P clears, both flags, pin undriven
    wr(`ADDR_CMPP, 32'h1);
    wr(`ADDR_CTRL1, 32'hC0);
    wr(`ADDR_CTRL0, 32'h18);
    tick(300);
    wr(`ADDR_CTRL0, 32'h0);
    rdc(`ADDR_CNT_HI, 32'h0, "counter high");
    chk("flags", 32'h3, 32'({match_p_flag, match_a_flag}));
    chk("pin enable", 32'h0, 32'(timer_output_oe));
    wr(`ADDR_FLAGS, 32'h3);
    wr(`ADDR_CMPP, 32'h0);
    wr(`ADDR_CTRL0, 32'h18);
    tick(40);
    wr(`ADDR_CTRL0, 32'h98);
    xfer(`ADDR_CNT_LO, 1'h0, 32'h0);
    r0 = rv;
    tick(10);
    rdc(`ADDR_CNT_LO, r0, "paused count");
    wr(`ADDR_CTRL0, 32'h18);
    tick(10);
    wr(`ADDR_CTRL0, 32'h0);
    xfer(`ADDR_CNT_LO, 1'h0, 32'h0);
    r0 = rv;
    tick(10);
    rdc(`ADDR_CNT_LO, r0, "held count");
    wr(`ADDR_CTRL0, 32'h18);
    xfer(`ADDR_CNT_LO, 1'h0, 32'h0);
    chk("restart count", 32'h1, 32'(rv < 32'h8));
    $display("test timer done");
    // pwm, period from P, duty from A
    wr(`ADDR_CTRL0, 32'h0);
    wr(`ADDR_FLAGS, 32'h3);
    wr(`ADDR_CMPA_LO, 32'h40);
    wr(`ADDR_CMPP, 32'h1);
    wr(`ADDR_CTRL1, 32'hA8);
    wr(`ADDR_CTRL0, 32'h18);
    repeat (3) meas(600);
    c2 = c;
    hl = lvl;
    meas(600);
    chk("pwm period", 32'h100, 32'(c + c2));
    chk("pwm duty", 32'h40, 32'(hl ? c2 : c));
    chk("pwm flags", 32'h3, 32'({match_p_flag, match_a_flag}));
    wr(`ADDR_CMPA_LO, 32'h64);
    for (int k = 0; k < 4; k++)
    begin
      wr(`ADDR_CTRL0, 32'h0);
      wr(`ADDR_CTRL1, 32'(c1v[k]));
      wr(`ADDR_CTRL0, 32'h18);
      tick(4);
      meas(300);
      chk("steady level", 32'(pex[k]), 32'(lvl));
      chk("steady time", 32'h12C, 32'(c));
    end
    $display("test pwm done");
    // single pulse, software start and A match end
    wr(`ADDR_CTRL0, 32'h0);
    wr(`ADDR_CMPA_LO, 32'h20);
    wr(`ADDR_CTRL1, 32'hB8);
    wr(`ADDR_CTRL0, 32'h18);
    meas(100);
    chk("pulse lead", 32'h0, 32'(lvl));
    meas(100);
    chk("pulse width", 32'h20, 32'(c));
    rdc(`ADDR_CTRL0, 32'h10, "enable after pulse");
    chk("pulse flag", 32'h1, 32'(match_a_flag));
    wr(`ADDR_CTRL0, 32'h60);
    ext_clock_pin <= 1'h1;
    tick(4);
    chk("pulse by pin", 32'h1, 32'(timer_output_pin));
    rdc(`ADDR_CTRL0, 32'h68, "enable by pin");
    ext_clock_pin <= 1'h0;
    $display("test single pulse done");
    conclude();
  end
endmodule // std_timer_tb
`default_nettype wire
